// *** rtl/dac_serial_device.sv ***
// converter end: three-wire shift/latch and async framed receiver
`timescale 1ns/1ps
module dac_serial_device
  import dac_serial_pkg::*;
(
  input  wire logic               clk,         // system clock
  input  wire logic               arst_n,      // async reset, low
  dac_serial_if.device            pins,        // serial pins
  input  wire logic               clear,       // force minimum code
  input  wire logic               loop_fault,  // analog fault sense
  output logic [CODE_W-1:0]       dac_code,    // code to converter
  output logic                    code_update, // pulse on new code
  output logic                    frame_error, // pulse on bad stop
  output logic                    async_mode   // mode in use
);
  // two-flop synchronisers for every pin input
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       clk_prev_q;
  logic       str_prev_q;
  logic       din_prev_q;
  logic       s_clk;
  logic       s_din;
  logic       s_str;
  logic       clk_rise;
  logic       str_rise;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {pins.load_strobe, pins.data_in, pins.data_clk};
      sync2_q <= sync1_q;
    end
  end

  assign s_clk = sync2_q[0];
  assign s_din = sync2_q[1];
  assign s_str = sync2_q[2];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_prev_q <= 1'b0;
      str_prev_q <= 1'b0;
      din_prev_q <= 1'b1;
    end else begin
      clk_prev_q <= s_clk;
      str_prev_q <= s_str;
      din_prev_q <= s_din;
    end
  end

  assign clk_rise = s_clk & ~clk_prev_q;
  assign str_rise = s_str & ~str_prev_q;

  // mode: strobe held high means async; a strobe that has been high for
  // a full bit cell of data clocks is taken as the tie-off.
  logic [4:0] hi_cnt_q;
  logic       async_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hi_cnt_q <= 5'h0_000;
      async_q  <= 1'b0;
    end else if (!s_str) begin
      hi_cnt_q <= 5'h0_000;
      async_q  <= 1'b0;
    end else if (clk_rise && hi_cnt_q != BIT_CNT_STOP) begin
      hi_cnt_q <= hi_cnt_q + 5'h0_001;
    end else if (hi_cnt_q == BIT_CNT_STOP) begin
      async_q  <= 1'b1;
    end
  end

  assign async_mode = async_q;

  // three-wire shift register
  logic [CODE_W-1:0] shift_q;
  logic              tw_load;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= CODE_RESET;
    end else if (!async_q && clk_rise) begin
      shift_q <= {shift_q[CODE_W-2:0], s_din};
    end
  end

  assign tw_load = !async_q && str_rise && !s_clk;

  // async receiver; counts data clock rises, not system clocks
  rx_state_type      rx_q;
  logic [4:0]        cell_q;
  logic [4:0]        bit_q;
  logic [CODE_W-1:0] rx_word_q;
  logic              rx_ok;
  logic              rx_bad;
  logic              mid_cell;

  assign mid_cell = clk_rise && (cell_q == HALF_CELL - 5'h0_001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_q      <= RX_IDLE;
      cell_q    <= 5'h0_000;
      bit_q     <= 5'h0_000;
      rx_word_q <= CODE_RESET;
    end else if (!async_q) begin
      rx_q   <= RX_IDLE;
      cell_q <= 5'h0_000;
    end else begin
      unique case (rx_q)
        RX_IDLE: begin
          cell_q <= 5'h0_000;
          if (!s_din && din_prev_q) begin
            rx_q <= RX_START;
          end
        end
        RX_START: begin
          if (clk_rise) begin
            cell_q <= (cell_q == CELL_LAST) ? 5'h0_000 : cell_q + 5'h0_001;
            if (mid_cell && s_din) begin
              rx_q <= RX_IDLE;                        // glitch, not a start
            end else if (cell_q == CELL_LAST) begin
              rx_q  <= RX_DATA;
              bit_q <= 5'h0_000;
            end
          end
        end
        RX_DATA: begin
          if (clk_rise) begin
            cell_q <= (cell_q == CELL_LAST) ? 5'h0_000 : cell_q + 5'h0_001;
            if (mid_cell) begin
              rx_word_q <= {rx_word_q[CODE_W-2:0], s_din};
              bit_q     <= bit_q + 5'h0_001;
            end
            if (cell_q == CELL_LAST && bit_q == BIT_CNT_STOP) begin
              rx_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (mid_cell) begin
            rx_q <= RX_IDLE;
          end else if (clk_rise) begin
            cell_q <= cell_q + 5'h0_001;
          end
        end
      endcase
    end
  end

  assign rx_ok  = async_q && rx_q == RX_STOP && mid_cell && s_din;
  assign rx_bad = async_q && rx_q == RX_STOP && mid_cell && !s_din;

  // converter code latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_code    <= CODE_RESET;
      code_update <= 1'b0;
    end else if (clear) begin
      dac_code    <= CODE_MIN;
      code_update <= 1'b0;
    end else begin
      code_update <= tw_load | rx_ok;
      if (tw_load) begin
        dac_code <= shift_q;
      end else if (rx_ok) begin
        dac_code <= rx_word_q;
      end
    end
  end

  // error pulse lasts one data clock period after the stop sample
  logic err_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'b0;
    end else if (rx_bad) begin
      err_q <= 1'b1;
    end else if (clk_rise) begin
      err_q <= 1'b0;
    end
  end

  assign frame_error = rx_bad;

  logic dout_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_q <= 1'b0;
    end else if (async_q) begin
      // drop with the next data clock rise so the pulse spans one period
      dout_q <= rx_bad | (err_q & ~clk_rise);
    end else begin
      dout_q <= shift_q[CODE_W-1];
    end
  end

  assign pins.data_out = dout_q;
  assign pins.fault_o  = 1'b0;

  // open drain: only ever pulls low, shared pull-up outside
  logic fault_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= loop_fault;
    end
  end

  assign pins.fault_oe = fault_q;
endmodule

// *** rtl/dac_serial_pkg.sv ***
// shared constants for the dac serial input interface
package dac_serial_pkg;
  localparam int          CODE_W        = 16;
  localparam int          CELL_CYCLES   = 16;
  localparam logic [4:0]  CELL_LAST     = 5'h0_00F;
  localparam logic [4:0]  HALF_CELL     = 5'h0_008;
  localparam logic [4:0]  BIT_CNT_STOP  = 5'h0_010;
  localparam logic [15:0] CODE_RESET    = 16'h0000;
  localparam logic [15:0] CODE_MIN      = 16'h0000;
  localparam logic [4:0]  HOST_DIV_HALF = 5'h0_001;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_type;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_START,
    TX_DATA,
    TX_STOP,
    TW_SHIFT,
    TW_LATCH
  } tx_state_type;
endpackage

// *** rtl/dac_serial_if.sv ***
// pin bundle between the host controller and the converter input
`timescale 1ns/1ps
interface dac_serial_if;
  logic data_clk;      // data clock made by the host
  logic data_in;       // serial data toward the converter
  logic load_strobe;   // load strobe, held high for async mode
  logic data_out;      // daisy chain out / framing error pulse
  logic fault_o;       // fault driver level (always low)
  logic fault_oe;      // fault driver enable, high pulls low
  logic fault_n;       // wired fault line as seen by the host

  assign fault_n = fault_oe ? fault_o : 1'b1;

  modport device (
    input  data_clk, data_in, load_strobe,
    output data_out, fault_o, fault_oe
  );
  modport host (
    output data_clk, data_in, load_strobe,
    input  data_out, fault_n
  );
endinterface

// *** rtl/dac_serial_host.sv ***
// host end: sends codes in three-wire or async framed form
`timescale 1ns/1ps
module dac_serial_host
  import dac_serial_pkg::*;
(
  input  wire logic               clk,        // system clock
  input  wire logic               arst_n,     // async reset, low
  dac_serial_if.host              pins,       // serial pins
  input  wire logic               use_async,  // select async framing
  input  wire logic               send_valid, // request to send code
  input  wire logic [CODE_W-1:0]  send_code,  // code to send
  output logic                    send_ready, // idle, takes request
  output logic                    frame_err,  // error pulse seen
  output logic                    fault_seen  // wired fault active
);
  tx_state_type      st_q;
  logic [CODE_W-1:0] word_q;
  logic [4:0]        bit_q;
  logic [4:0]        cell_q;
  logic [4:0]        div_q;
  logic              dclk_q;
  logic              din_q;
  logic              str_q;
  logic              tick;
  logic              pclk_q;
  logic              run;

  // data clock divider; runs free
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q  <= 5'h0_000;
      dclk_q <= 1'b0;
    end else if (div_q == HOST_DIV_HALF) begin
      div_q  <= 5'h0_000;
      dclk_q <= ~dclk_q;
    end else begin
      div_q <= div_q + 5'h0_001;
    end
  end

  // tick marks the falling data clock edge: change data there
  assign tick = dclk_q && div_q == HOST_DIV_HALF;
  assign send_ready = st_q == TX_IDLE;

  // the pin clock runs only while a word shifts or async mode is up; a
  // free clock in three-wire mode would push the held word out of the
  // converter and would rise while the strobe is high
  assign run = (use_async && str_q) || st_q == TW_SHIFT;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pclk_q <= 1'b0;
    end else if (div_q == HOST_DIV_HALF) begin
      pclk_q <= ~dclk_q & run;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q   <= TX_IDLE;
      word_q <= CODE_RESET;
      bit_q  <= 5'h0_000;
      cell_q <= 5'h0_000;
      din_q  <= 1'b1;
      str_q  <= 1'b0;
    end else begin
      unique case (st_q)
        TX_IDLE: begin
          // strobe moves only as the data clock falls
          if (tick) begin
            str_q <= use_async;
          end
          din_q <= 1'b1;
          if (send_valid && tick) begin
            word_q <= send_code;
            bit_q  <= 5'h0_000;
            cell_q <= 5'h0_000;
            st_q   <= use_async ? TX_START : TW_SHIFT;
            din_q  <= use_async ? 1'b0 : send_code[CODE_W-1];
            str_q  <= use_async;
          end
        end
        TX_START: begin
          if (tick) begin
            cell_q <= cell_q + 5'h0_001;
            if (cell_q == CELL_LAST) begin
              cell_q <= 5'h0_000;
              din_q  <= word_q[CODE_W-1];
              word_q <= {word_q[CODE_W-2:0], 1'b0};
              bit_q  <= 5'h0_001;
              st_q   <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          if (tick) begin
            cell_q <= cell_q + 5'h0_001;
            if (cell_q == CELL_LAST) begin
              cell_q <= 5'h0_000;
              if (bit_q == BIT_CNT_STOP) begin
                din_q <= 1'b1;
                st_q  <= TX_STOP;
              end else begin
                din_q  <= word_q[CODE_W-1];
                word_q <= {word_q[CODE_W-2:0], 1'b0};
                bit_q  <= bit_q + 5'h0_001;
              end
            end
          end
        end
        TX_STOP: begin
          if (tick) begin
            cell_q <= cell_q + 5'h0_001;
            if (cell_q == CELL_LAST) begin
              st_q <= TX_IDLE;
            end
          end
        end
        TW_SHIFT: begin
          if (tick) begin
            bit_q  <= bit_q + 5'h0_001;
            word_q <= {word_q[CODE_W-2:0], 1'b0};
            din_q  <= word_q[CODE_W-2];
            if (bit_q == BIT_CNT_STOP - 5'h0_001) begin
              st_q <= TW_LATCH;
            end
          end
        end
        TW_LATCH: begin
          // clock is low right after tick: raise strobe then
          if (!dclk_q && !str_q) begin
            str_q <= 1'b1;
          end else if (tick) begin
            str_q <= 1'b0;
            st_q  <= TX_IDLE;
          end
        end
        default: st_q <= TX_IDLE;
      endcase
    end
  end

  assign pins.data_clk    = pclk_q;
  assign pins.data_in     = din_q;
  assign pins.load_strobe = str_q;

  logic [1:0] dout_s_q;
  logic [1:0] flt_s_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_s_q   <= 2'h0;
      flt_s_q    <= 2'h3;
      frame_err  <= 1'b0;
      fault_seen <= 1'b0;
    end else begin
      dout_s_q   <= {dout_s_q[0], pins.data_out};
      flt_s_q    <= {flt_s_q[0], pins.fault_n};
      frame_err  <= use_async & dout_s_q[1];
      fault_seen <= ~flt_s_q[1];
    end
  end
endmodule

// *** verif/dac_serial_assertions.sv ***
// concurrent checks on the host to converter pin bundle
`timescale 1ns/1ps
module dac_serial_assertions (
  input wire logic clk,         // system clock
  input wire logic arst_n,      // async reset, low
  input wire logic data_clk,    // data clock
  input wire logic data_in,     // serial data
  input wire logic load_strobe, // strobe / mode
  input wire logic data_out,    // device serial out
  input wire logic fault_o,     // fault driver level
  input wire logic fault_oe,    // fault driver enable
  input wire logic fault_n      // wired fault line
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  fault_drive_low_a: assert property (
    fault_oe |-> !fault_o && !fault_n) else $error("fault not pulled low");
  clk_high_hold_a: assert property (
    $rose(data_clk) |=> data_clk) else $error("data clock high too short");
  clk_low_hold_a: assert property (
    $fell(data_clk) |=> !data_clk) else $error("data clock low too short");
  shift_data_low_a: assert property (
    $changed(data_in) && !load_strobe && !$past(load_strobe) |-> !data_clk)
    else $error("data moved while clock high");
  latch_clock_low_a: assert property (
    $rose(load_strobe) |-> !data_clk) else $error("strobe rose, clock high");
  strobe_low_shift_a: assert property (
    $rose(data_clk) && !load_strobe |-> !load_strobe [*3])
    else $error("strobe moved while shifting");
  start_bit_hold_a: assert property (
    load_strobe && $fell(data_in) |-> !data_in [*8])
    else $error("start bit too short");
  async_high_hold_a: assert property (
    load_strobe && $rose(data_in) |-> data_in [*8])
    else $error("high cell too short");

  cover property ($rose(load_strobe));
  cover property (load_strobe && $fell(data_in));
  cover property ($rose(fault_oe));
endmodule

// *** verif/tb_dac_serial_input_interface.sv ***
// self-checking bench: host and converter ends, plus a rogue async driver
`timescale 1ns/1ps
module tb_dac_serial_input_interface;
  import dac_serial_pkg::*;
  logic              clk, arst_n, clear, loop_fault, use_async;
  logic              send_valid, send_ready, frame_err, fault_seen;
  logic              code_update, frame_error, async_mode, upd2, fe2, am2;
  logic [CODE_W-1:0] send_code, dac_code, code2;
  int                n_fail, compares, fe_cnt, do_cnt, up_cnt, fe1_cnt;

  dac_serial_if ifc();
  dac_serial_if bif();

  dac_serial_host dac_serial_host_i (.clk(clk), .arst_n(arst_n), .pins(ifc),
    .use_async(use_async), .send_valid(send_valid), .send_code(send_code),
    .send_ready(send_ready), .frame_err(frame_err), .fault_seen(fault_seen));
  dac_serial_device dac_serial_device_i (.clk(clk), .arst_n(arst_n),
    .pins(ifc), .clear(clear), .loop_fault(loop_fault), .dac_code(dac_code),
    .code_update(code_update), .frame_error(frame_error),
    .async_mode(async_mode));
  // second converter end faces a bench driver that can break framing
  dac_serial_device dac_serial_device_i2 (.clk(clk), .arst_n(arst_n),
    .pins(bif), .clear(1'b0), .loop_fault(1'b0), .dac_code(code2),
    .code_update(upd2), .frame_error(fe2), .async_mode(am2));
  dac_serial_assertions dac_serial_assertions_i (.clk(clk), .arst_n(arst_n),
    .data_clk(ifc.data_clk), .data_in(ifc.data_in),
    .load_strobe(ifc.load_strobe), .data_out(ifc.data_out),
    .fault_o(ifc.fault_o), .fault_oe(ifc.fault_oe), .fault_n(ifc.fault_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    if (fe2 === 1'b1) fe_cnt++;
    if (bif.data_out === 1'b1) do_cnt++;
    if (code_update === 1'b1) up_cnt++;
    if (frame_error === 1'b1) fe1_cnt++;
  end

  task automatic close_out;
    $display("compares %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic timeout;
    n_fail++;
    close_out();
  endtask

  task automatic send(input logic [15:0] c);
    int i;
    for (i = 0; i < 5000 && send_ready !== 1'b1; i++) tick(1);
    if (i == 5000) timeout();
    send_code = c;
    send_valid = 1'b1;
    for (i = 0; i < 5000 && send_ready === 1'b1; i++) tick(1);
    send_valid = 1'b0;
    if (i == 5000) timeout();
  endtask

  task automatic wait_code(input logic [15:0] exp, input bit second);
    int i;
    for (i = 0; i < 3000; i++) begin
      if ((second ? code2 : dac_code) === exp) break;
      tick(1);
    end
    if (i == 3000) timeout();
  endtask

  // rogue driver: data moves one clock before each run of data clocks
  task automatic cells(input int n, input logic b);
    bif.data_in = b;
    tick(1);
    repeat (n) begin
      bif.data_clk = 1'b1;
      tick(2);
      bif.data_clk = 1'b0;
      tick(2);
    end
  endtask

  task automatic frame(input logic [15:0] c, input logic stop);
    int k;
    cells(CELL_CYCLES, 1'b0);
    for (k = 15; k >= 0; k--) cells(CELL_CYCLES, c[k]);
    cells(CELL_CYCLES, stop);
    cells(4, 1'b1);
  endtask

  task automatic t_three_wire;
    up_cnt = 0;
    send(16'h1234);
    wait_code(16'h1234, 1'b0);
    check(dac_code, 16'h1234);
    tick(2);
    check(16'(up_cnt), 16'h0001);
    $display("done three_wire");
  endtask

  task automatic t_clear_daisy;
    int k;
    clear = 1'b1;
    tick(4);
    check(dac_code, CODE_MIN);
    clear = 1'b0;
    tick(4);
    check(dac_code, CODE_MIN);
    fork
      send(16'hBEEF);
      for (k = 15; k >= 0; k--) begin
        @(negedge ifc.data_clk);
        check(16'(ifc.data_out), 16'((16'h1234 >> k) & 16'h0001));
      end
    join
    wait_code(16'hBEEF, 1'b0);
    check(dac_code, 16'hBEEF);
    $display("done clear_daisy");
  endtask

  task automatic t_fault;
    loop_fault = 1'b1;
    tick(4);
    check(16'(ifc.fault_n), 16'h0000);
    check(16'(fault_seen), 16'h0001);
    loop_fault = 1'b0;
    tick(4);
    check(16'(ifc.fault_n), 16'h0001);
    $display("done fault");
  endtask

  task automatic t_async;
    int i;
    use_async = 1'b1;
    for (i = 0; i < 3000 && async_mode !== 1'b1; i++) tick(1);
    check(16'(async_mode), 16'h0001);
    send(16'hA5C3);
    wait_code(16'hA5C3, 1'b0);
    check(dac_code, 16'hA5C3);
    check(16'(frame_err), 16'h0000);
    check(16'(fe1_cnt), 16'h0000);
    $display("done async");
  endtask

  task automatic t_bad_frame;
    cells(20, 1'b1);
    check(16'(am2), 16'h0001);
    fe_cnt = 0;
    do_cnt = 0;
    frame(16'h0F0F, 1'b0);
    check(16'(fe_cnt), 16'h0001);
    check(16'(do_cnt), 16'h0004);
    check(code2, CODE_RESET);
    frame(16'h3C96, 1'b1);
    wait_code(16'h3C96, 1'b1);
    check(code2, 16'h3C96);
    check(16'(fe_cnt), 16'h0001);
    $display("done bad_frame");
  endtask

  // watchdog: a wait on a pin edge that never comes still ends the run
  initial begin
    repeat (20000) @(posedge clk);
    timeout();
  end

  initial begin
    n_fail = 0;
    compares = 0;
    arst_n = 1'b0;
    clear = 1'b0;
    loop_fault = 1'b0;
    use_async = 1'b0;
    send_valid = 1'b0;
    send_code = 16'h0000;
    bif.data_clk = 1'b0;
    bif.data_in = 1'b1;
    bif.load_strobe = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    arst_n = 1'b1;
    tick(1);
    t_three_wire();
    t_clear_daisy();
    t_fault();
    t_async();
    t_bad_frame();
    close_out();
  end
endmodule
